// [shared/tcs_pkg.sv]
package tcs_pkg;
  // register byte addresses
  localparam logic [15:0] ADR_IOSEL = 16'hffe2;
  localparam logic [15:0] ADR_TRIG = 16'hffe4;
  localparam logic [15:0] ADR_STATUS = 16'hffe5;
  localparam logic [15:0] ADR_COUNT = 16'hffe6;
  localparam logic [15:0] ADR_GRA = 16'hffe8;
  localparam logic [15:0] ADR_GRB = 16'hffea;
  localparam logic [15:0] ADR_CTRL = 16'hfff0;
  localparam logic [15:0] ADR_MODE = 16'hfff1;
  // status field positions
  localparam int ST_FLAG_A = 0;
  localparam int ST_FLAG_B = 1;
  localparam int ST_OVF = 4;
  localparam int ST_UDF = 5;
  localparam int ST_FIX1 = 6;
  localparam int ST_DIR = 7;
  // control fields
  localparam int CT_PSC_LO = 0;
  localparam int CT_EDG_LO = 3;
  localparam int CT_CLR_LO = 5;
  localparam int MD_LO = 0;
  localparam int TRIG_EN_POS = 7;
  localparam int TRIG_FIX1 = 6;
  localparam int IO_CAP_A = 0;
  localparam int IO_CAP_B = 1;
  // reset values
  localparam logic [15:0] GR_RST = 16'hffff;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [7:0] MODE_FIX = 8'hc0;
  // counter clear sources
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_GRA = 2'h1;
  localparam logic [1:0] CLR_GRB = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  // prescaler codes and divider widths
  localparam logic [2:0] PSC_D1 = 3'h0;
  localparam logic [2:0] PSC_D4 = 3'h1;
  localparam logic [2:0] PSC_D16 = 3'h2;
  localparam logic [2:0] PSC_D64 = 3'h3;
  localparam logic [2:0] PSC_EXA = 3'h4;
  localparam logic [2:0] PSC_EXB = 3'h5;
  localparam logic [2:0] PSC_EXC = 3'h6;
  localparam logic [2:0] PSC_D1024 = 3'h7;
  localparam int LOG_D4 = 2;
  localparam int LOG_D16 = 4;
  localparam int LOG_D64 = 6;
  localparam int LOG_D1024 = 10;
  // edge codes and phase mode high bits
  localparam logic [1:0] EDG_RISE = 2'h0;
  localparam logic [1:0] EDG_FALL = 2'h1;
  localparam logic [1:0] PHASE_MODE_HI = 2'h1;
endpackage

// [shared/tcs_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface tcs_tick_if;
  logic [2:0] prescale;
  logic [1:0] edge_sel;
  logic phase;
  logic tick;
  logic down;
  modport gen (
    input prescale,
    input edge_sel,
    input phase,
    output tick,
    output down
  );
  modport use_side (
    output prescale,
    output edge_sel,
    output phase,
    input tick,
    input down
  );
endinterface
`default_nettype wire

// [verilog/tcs_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module tcs_tick (
  // clock and control
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // external clock pins
  input wire logic ext_clock_pin_a_in,
  input wire logic ext_clock_pin_b_in,
  input wire logic ext_clock_pin_c_in,
  // count request to the channel
  tcs_tick_if.gen tk
);
  typedef struct packed {
    logic [tcs_pkg::LOG_D1024-1:0] pre;
    logic [2:0] pins;
  } tcs_tick_st_t;
  tcs_tick_st_t st_r;
  tcs_tick_st_t st_nxt;
  logic [2:0] now;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] hit;
  logic up;
  always_comb begin
    now = {ext_clock_pin_c_in, ext_clock_pin_b_in, ext_clock_pin_a_in};
    rise = now & ~st_r.pins;
    fall = ~now & st_r.pins;
    st_nxt.pre = st_r.pre + 1'b1;
    st_nxt.pins = now;
    if (tk.edge_sel == tcs_pkg::EDG_RISE) begin
      hit = rise;
    end else if (tk.edge_sel == tcs_pkg::EDG_FALL) begin
      hit = fall;
    end else begin
      hit = rise | fall;
    end
    // a leading b counts up
    up = (rise[0] & ~now[1]) | (fall[0] & now[1]) |
      (rise[1] & now[0]) | (fall[1] & ~now[0]);
    tk.down = 1'b0;
    if (!ce_in) begin
      tk.tick = 1'b0;
    end else if (tk.phase) begin
      // edge and prescaler fields do not apply here
      tk.tick = (rise[0] | fall[0] | rise[1] | fall[1]);
      tk.down = ~up;
    end else begin
      case (tk.prescale)
        tcs_pkg::PSC_D1: tk.tick = 1'b1;
        tcs_pkg::PSC_D4: tk.tick = &st_r.pre[tcs_pkg::LOG_D4-1:0];
        tcs_pkg::PSC_D16: tk.tick = &st_r.pre[tcs_pkg::LOG_D16-1:0];
        tcs_pkg::PSC_D64: tk.tick = &st_r.pre[tcs_pkg::LOG_D64-1:0];
        tcs_pkg::PSC_EXA: tk.tick = hit[0];
        tcs_pkg::PSC_EXB: tk.tick = hit[1];
        tcs_pkg::PSC_EXC: tk.tick = hit[2];
        default: tk.tick = &st_r.pre;
      endcase
    end
  end
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end
endmodule // tcs_tick
`default_nettype wire

// [verilog/tcs_timer.sv]
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - transfer controller ack on a, with select bit 0, clears flag a
// - software clears flag a only with a 0 write after reading it as 1
// - compare a: flag a sets when count equals register a
// - capture a: flag a sets when count is copied into register a
// - transfer controller ack on b, with select bit 0, clears flag b
// - software clears flag b only with a 0 write after reading it as 1
// - flag b sets on compare match or capture into register b
// - overflow flag sets when count wraps from all ones to zero
// - overflow flag clears only on 0 write after reading it set
// - underflow flag sets on wrap from zero; clears like overflow
// - read-only direction flag shows up or down counting
// - writing 1 to a status flag has no effect
// - only phase counting counts down; otherwise count up
// - edge and prescaler fields ignored in phase counting
// - clear field: none, register a, register b, or sync clear
// - code 11 clears count when another channel clears its count
// - mode codes: normal, reserved, two pwm, four phase modes
// - trigger enable gates the converter start request
module tcs_timer #(
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // register port
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // pins
  input wire logic ext_clock_pin_a_in,
  input wire logic ext_clock_pin_b_in,
  input wire logic ext_clock_pin_c_in,
  input wire logic capture_a_in,
  input wire logic capture_b_in,
  // other channel and transfer controller
  input wire logic sync_clear_in,
  input wire logic dtc_ack_a_in,
  input wire logic dtc_ack_b_in,
  input wire logic transfer_irq_select_a_in,
  input wire logic transfer_irq_select_b_in,
  // events
  output logic match_irq_a_out,
  output logic match_irq_b_out,
  output logic overflow_irq_out,
  output logic underflow_irq_out,
  output logic adc_start_out,
  output logic counter_cleared_out
);
  if (CNT_W < 2 || CNT_W > 16) begin : g_chk
    $error("tcs_timer: CNT_W must be 2 to 16");
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] gra;
    logic [CNT_W-1:0] grb;
    logic [6:0] ctrl;
    logic [3:0] mode;
    logic trig_en;
    logic cap_a;
    logic cap_b;
    logic flag_a;
    logic flag_b;
    logic ovf;
    logic udf;
    logic dir_up;
    logic [3:0] armed;
    logic [15:0] rdata;
    logic adc_start;
    logic cleared;
  } tcs_state_t;

  localparam tcs_state_t ST_RST = '{
    count: '0,
    gra: tcs_pkg::GR_RST[CNT_W-1:0],
    grb: tcs_pkg::GR_RST[CNT_W-1:0],
    ctrl: tcs_pkg::CTRL_RST,
    mode: tcs_pkg::MODE_RST,
    trig_en: 1'b0,
    cap_a: 1'b0,
    cap_b: 1'b0,
    flag_a: 1'b0,
    flag_b: 1'b0,
    ovf: 1'b0,
    udf: 1'b0,
    dir_up: 1'b1,
    armed: 4'h0,
    rdata: 16'h0000,
    adc_start: 1'b0,
    cleared: 1'b0
  };

  tcs_state_t st_r;
  tcs_state_t st_nxt;
  tcs_tick_if tk ();

  tcs_tick u_tick (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .ext_clock_pin_a_in(ext_clock_pin_a_in),
    .ext_clock_pin_b_in(ext_clock_pin_b_in),
    .ext_clock_pin_c_in(ext_clock_pin_c_in),
    .tk(tk.gen)
  );

  logic [1:0] clr_sel;
  logic [7:0] status;
  logic wr_st;
  logic rd_st;
  logic cmp_a;
  logic cmp_b;
  logic ev_a;
  logic ev_b;
  logic dn;
  logic do_clr;
  logic clr_a;
  logic clr_b;
  logic clr_v;
  logic clr_u;
  logic set_v;
  logic set_u;
  logic [15:0] cnt_w;
  logic [15:0] gra_w;
  logic [15:0] grb_w;

  assign clr_sel = st_r.ctrl[tcs_pkg::CT_CLR_LO +: 2];
  assign tk.prescale = st_r.ctrl[tcs_pkg::CT_PSC_LO +: 3];
  assign tk.edge_sel = st_r.ctrl[tcs_pkg::CT_EDG_LO +: 2];
  // 0100..0111 all count by phase; pwm codes only stored
  assign tk.phase = st_r.mode[3:2] == tcs_pkg::PHASE_MODE_HI;

  always_comb begin
    status = 8'h00;
    status[tcs_pkg::ST_FLAG_A] = st_r.flag_a;
    status[tcs_pkg::ST_FLAG_B] = st_r.flag_b;
    status[tcs_pkg::ST_OVF] = st_r.ovf;
    status[tcs_pkg::ST_UDF] = st_r.udf;
    status[tcs_pkg::ST_FIX1] = 1'b1;
    status[tcs_pkg::ST_DIR] = st_r.dir_up;
    cnt_w = 16'h0000;
    gra_w = 16'h0000;
    grb_w = 16'h0000;
    cnt_w[CNT_W-1:0] = st_r.count;
    gra_w[CNT_W-1:0] = st_r.gra;
    grb_w[CNT_W-1:0] = st_r.grb;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.adc_start = 1'b0;
    st_nxt.cleared = 1'b0;
    st_nxt.rdata = 16'h0000;
    wr_st = wr_in && addr_in == tcs_pkg::ADR_STATUS;
    rd_st = rd_in && addr_in == tcs_pkg::ADR_STATUS;

    // software writes first; hardware events below override them
    if (wr_in) begin
      if (addr_in == tcs_pkg::ADR_GRA) begin
        st_nxt.gra = wdata_in[CNT_W-1:0];
      end else if (addr_in == tcs_pkg::ADR_GRB) begin
        st_nxt.grb = wdata_in[CNT_W-1:0];
      end else if (addr_in == tcs_pkg::ADR_COUNT) begin
        st_nxt.count = wdata_in[CNT_W-1:0];
      end else if (addr_in == tcs_pkg::ADR_CTRL) begin
        st_nxt.ctrl = wdata_in[6:0];
      end else if (addr_in == tcs_pkg::ADR_MODE) begin
        // top bit kept as written; software keeps it 0
        st_nxt.mode = wdata_in[tcs_pkg::MD_LO +: 4];
      end else if (addr_in == tcs_pkg::ADR_TRIG) begin
        st_nxt.trig_en = wdata_in[tcs_pkg::TRIG_EN_POS];
      end else if (addr_in == tcs_pkg::ADR_IOSEL) begin
        st_nxt.cap_a = wdata_in[tcs_pkg::IO_CAP_A];
        st_nxt.cap_b = wdata_in[tcs_pkg::IO_CAP_B];
      end
    end

    // read data stands only in the cycle after the strobe
    if (rd_in) begin
      if (addr_in == tcs_pkg::ADR_STATUS) begin
        st_nxt.rdata = {8'h00, status};
      end else if (addr_in == tcs_pkg::ADR_GRA) begin
        st_nxt.rdata = gra_w;
      end else if (addr_in == tcs_pkg::ADR_GRB) begin
        st_nxt.rdata = grb_w;
      end else if (addr_in == tcs_pkg::ADR_COUNT) begin
        st_nxt.rdata = cnt_w;
      end else if (addr_in == tcs_pkg::ADR_CTRL) begin
        st_nxt.rdata = {9'h000, st_r.ctrl};
      end else if (addr_in == tcs_pkg::ADR_MODE) begin
        st_nxt.rdata = {8'h00, tcs_pkg::MODE_FIX | {4'h0, st_r.mode}};
      end else if (addr_in == tcs_pkg::ADR_TRIG) begin
        st_nxt.rdata[tcs_pkg::TRIG_EN_POS] = st_r.trig_en;
        st_nxt.rdata[tcs_pkg::TRIG_FIX1] = 1'b1;
      end else if (addr_in == tcs_pkg::ADR_IOSEL) begin
        st_nxt.rdata[tcs_pkg::IO_CAP_A] = st_r.cap_a;
        st_nxt.rdata[tcs_pkg::IO_CAP_B] = st_r.cap_b;
      end
    end

    // compare uses the value before this tick's step
    cmp_a = !st_r.cap_a && tk.tick && st_r.count == st_r.gra;
    cmp_b = !st_r.cap_b && tk.tick && st_r.count == st_r.grb;
    ev_a = cmp_a || (st_r.cap_a && capture_a_in);
    ev_b = cmp_b || (st_r.cap_b && capture_b_in);
    dn = tk.phase && tk.down;
    set_v = 1'b0;
    set_u = 1'b0;

    if (tk.tick) begin
      st_nxt.dir_up = !dn;
      if (dn) begin
        st_nxt.count = st_r.count - 1'b1;
        set_u = st_r.count == '0;
      end else begin
        st_nxt.count = st_r.count + 1'b1;
        set_v = &st_r.count;
      end
    end

    // captured value is the count before any step
    if (st_r.cap_a && capture_a_in) begin
      st_nxt.gra = st_r.count;
    end
    if (st_r.cap_b && capture_b_in) begin
      st_nxt.grb = st_r.count;
    end

    case (clr_sel)
      tcs_pkg::CLR_GRA: do_clr = ev_a;
      tcs_pkg::CLR_GRB: do_clr = ev_b;
      // sync setup lives in the other channel's sync register
      tcs_pkg::CLR_SYNC: do_clr = sync_clear_in;
      default: do_clr = 1'b0;
    endcase
    if (do_clr) begin
      st_nxt.count = '0;
      st_nxt.cleared = 1'b1;
    end

    // armed bits remember a flag was read as 1
    clr_a = (dtc_ack_a_in && !transfer_irq_select_a_in) ||
      (wr_st && !wdata_in[tcs_pkg::ST_FLAG_A] && st_r.armed[0]);
    clr_b = (dtc_ack_b_in && !transfer_irq_select_b_in) ||
      (wr_st && !wdata_in[tcs_pkg::ST_FLAG_B] && st_r.armed[1]);
    clr_v = wr_st && !wdata_in[tcs_pkg::ST_OVF] && st_r.armed[2];
    clr_u = wr_st && !wdata_in[tcs_pkg::ST_UDF] && st_r.armed[3];

    // a set in the clearing cycle wins; a 1 write clears nothing
    st_nxt.flag_a = (st_r.flag_a && !clr_a) || ev_a;
    st_nxt.flag_b = (st_r.flag_b && !clr_b) || ev_b;
    st_nxt.ovf = (st_r.ovf && !clr_v) || set_v;
    st_nxt.udf = (st_r.udf && !clr_u) || set_u;

    if (rd_st) begin
      st_nxt.armed = {st_r.udf, st_r.ovf, st_r.flag_b, st_r.flag_a};
    end else if (wr_st) begin
      st_nxt.armed = 4'h0;
    end else begin
      st_nxt.armed = st_r.armed &
        {st_nxt.udf, st_nxt.ovf, st_nxt.flag_b, st_nxt.flag_a};
    end

    st_nxt.adc_start = ev_a && st_r.trig_en;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st_r <= ST_RST;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign match_irq_a_out = st_r.flag_a;
  assign match_irq_b_out = st_r.flag_b;
  assign overflow_irq_out = st_r.ovf;
  assign underflow_irq_out = st_r.udf;
  assign adc_start_out = st_r.adc_start;
  assign counter_cleared_out = st_r.cleared;
endmodule // tcs_timer
`default_nettype wire

// [verification/tcs_pins_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tcs_pins_model (
  // clock and commands from the bench
  input wire logic clock_in,
  input wire logic quad_on_in,
  input wire logic quad_down_in,
  input wire logic tog_c_in,
  // count pins toward the timer
  output logic pin_a_out,
  output logic pin_b_out,
  output var logic pin_c_out
);
  logic [1:0] ph_r = 2'h0;
  logic [1:0] div_r = 2'h0;
  initial pin_c_out = 1'b0;
  // gray walk: a leads when stepping up, b leads when stepping down
  assign pin_a_out = ph_r[1] ^ ph_r[0];
  assign pin_b_out = ph_r[1];
  always @(posedge clock_in) begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3 && quad_on_in) begin
      ph_r <= quad_down_in ? ph_r - 2'h1 : ph_r + 2'h1;
    end
    // slow toggle so every edge is seen by a synchroniser
    if (div_r[0] && tog_c_in) begin
      pin_c_out <= !pin_c_out;
    end
  end
endmodule // tcs_pins_model
`default_nettype wire

// [verification/tcs_timer_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module tcs_timer_checker #(
  parameter int CNT_W = 16
) (
  // watched ports
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic capture_a_in,
  input wire logic capture_b_in,
  input wire logic sync_clear_in,
  input wire logic dtc_ack_a_in,
  input wire logic dtc_ack_b_in,
  input wire logic transfer_irq_select_a_in,
  input wire logic transfer_irq_select_b_in,
  input wire logic match_irq_a_out,
  input wire logic match_irq_b_out,
  input wire logic overflow_irq_out,
  input wire logic underflow_irq_out,
  input wire logic adc_start_out,
  input wire logic counter_cleared_out
);
  logic [1:0] io_r;
  logic [1:0] clr_r;
  logic trg_r;
  logic wst;
  // shadow of capture use, clear source and trigger enable, seen from the bus only
  assign wst = wr_in && ce_in && addr_in == tcs_pkg::ADR_STATUS;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      io_r <= 2'h0;
      clr_r <= 2'h0;
      trg_r <= 1'b0;
    end else if (wr_in && ce_in && addr_in == tcs_pkg::ADR_IOSEL) begin
      io_r <= wdata_in[1:0];
    end else if (wr_in && ce_in && addr_in == tcs_pkg::ADR_CTRL) begin
      clr_r <= wdata_in[6:5];
    end else if (wr_in && ce_in && addr_in == tcs_pkg::ADR_TRIG) begin
      trg_r <= wdata_in[tcs_pkg::TRIG_EN_POS];
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  sequence s_stat_rd;
    rd_in && ce_in && addr_in == tcs_pkg::ADR_STATUS;
  endsequence
  a_flag_a_kept: assert property (
    match_irq_a_out && !(wst && !wdata_in[0])
    && !(dtc_ack_a_in && !transfer_irq_select_a_in) |=> match_irq_a_out)
    else $error("flag a dropped without a cause");
  a_flag_b_kept: assert property (
    match_irq_b_out && !(wst && !wdata_in[1])
    && !(dtc_ack_b_in && !transfer_irq_select_b_in) |=> match_irq_b_out)
    else $error("flag b dropped without a cause");
  a_ovf_kept: assert property (
    overflow_irq_out && !(wst && !wdata_in[4]) |=> overflow_irq_out)
    else $error("overflow flag dropped without a write");
  a_udf_kept: assert property (
    $fell(underflow_irq_out) |-> $past(wst && !wdata_in[5]))
    else $error("underflow flag dropped without a write");
  a_cap_a_sets: assert property (
    capture_a_in && ce_in && io_r[0] |=> match_irq_a_out)
    else $error("capture a did not set flag a");
  a_cap_b_sets: assert property (
    capture_b_in && ce_in && io_r[1] |=> match_irq_b_out)
    else $error("capture b did not set flag b");
  a_adc_with_a: assert property (
    adc_start_out |-> match_irq_a_out && !$past(adc_start_out))
    else $error("converter start without flag a");
  a_flag_readback: assert property (
    s_stat_rd |=> rdata_out[5:4] ==
      {$past(underflow_irq_out), $past(overflow_irq_out)})
    else $error("status read does not match flags");
  a_sync_clears: assert property (
    clr_r == tcs_pkg::CLR_SYNC && sync_clear_in && ce_in
    |=> counter_cleared_out)
    else $error("sync clear did not clear the count");
  a_clr_none_idle: assert property (
    clr_r == tcs_pkg::CLR_NONE && ce_in |=> !counter_cleared_out)
    else $error("count cleared while clearing is off");
  a_adc_needs_en: assert property (
    !trg_r && ce_in |=> !adc_start_out)
    else $error("converter start while trigger is off");
endmodule // tcs_timer_checker
bind tcs_timer tcs_timer_checker #(.CNT_W(CNT_W)) tcs_timer_checker_i (
  .clock_in, .srst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .capture_a_in, .capture_b_in, .sync_clear_in,
  .dtc_ack_a_in, .dtc_ack_b_in, .transfer_irq_select_a_in,
  .transfer_irq_select_b_in, .match_irq_a_out, .match_irq_b_out,
  .overflow_irq_out, .underflow_irq_out, .adc_start_out,
  .counter_cleared_out
);
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_in = 1'b0, srst_in = 1'b1, ce_in = 1'b1;
  logic [15:0] addr_in = 16'h0000, wdata_in = 16'h0000, rdata_out;
  logic wr_in = 1'b0, rd_in = 1'b0, q_on = 1'b0, q_dn = 1'b0;
  logic tog_c = 1'b0, transfer_irq_select_a_in = 1'b0;
  logic transfer_irq_select_b_in = 1'b0, rd_d = 1'b0, pc_d = 1'b0;
  logic [4:0] pv = 5'h00;
  logic capture_a_in, capture_b_in, sync_clear_in, dtc_ack_a_in;
  logic dtc_ack_b_in, ext_clock_pin_a_in, ext_clock_pin_b_in;
  logic ext_clock_pin_c_in, match_irq_a_out, match_irq_b_out;
  logic overflow_irq_out, underflow_irq_out, adc_start_out;
  logic counter_cleared_out;
  logic [3:0] fl;
  logic [31:0] ex;
  logic [31:0] q[$];
  int err_total = 0, n_compared = 0, adc_n = 0, clr_n = 0, c_edges = 0;
  int b, g;
  assign {dtc_ack_b_in, dtc_ack_a_in, sync_clear_in} = pv[4:2];
  assign {capture_b_in, capture_a_in} = pv[1:0];
  assign fl = {underflow_irq_out, overflow_irq_out, match_irq_b_out,
    match_irq_a_out};
  always #25 clock_in = ~clock_in;
  tcs_timer tcs_timer_i (
    .clock_in, .srst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .ext_clock_pin_a_in, .ext_clock_pin_b_in,
    .ext_clock_pin_c_in, .capture_a_in, .capture_b_in, .sync_clear_in,
    .dtc_ack_a_in, .dtc_ack_b_in, .transfer_irq_select_a_in,
    .transfer_irq_select_b_in, .match_irq_a_out, .match_irq_b_out,
    .overflow_irq_out, .underflow_irq_out, .adc_start_out,
    .counter_cleared_out
  );
  tcs_pins_model tcs_pins_model_i (
    .clock_in, .quad_on_in(q_on), .quad_down_in(q_dn), .tog_c_in(tog_c),
    .pin_a_out(ext_clock_pin_a_in), .pin_b_out(ext_clock_pin_b_in),
    .pin_c_out(ext_clock_pin_c_in)
  );
  task automatic chk(string s, logic [15:0] e, logic [15:0] v);
    n_compared++;
    if (v !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, v);
      err_total++;
    end
  endtask
  // a gap cycle after each strobe so no signal is driven twice per step
  task automatic wr(logic [15:0] a, logic [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] m, logic [15:0] e);
    q.push_back({m, e & m});
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic pulse(logic [4:0] v);
    pv <= v;
    @(posedge clock_in);
    pv <= 5'h00;
    @(posedge clock_in);
  endtask
  task automatic await(int k);
    for (int i = 0; i < 300 && fl[k] !== 1'b1; i++) @(posedge clock_in);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clock_in) begin
    if (rd_d) begin
      ex = q.pop_front();
      chk("rdata", ex[15:0], rdata_out & ex[31:16]);
    end
    rd_d <= rd_in;
    pc_d <= ext_clock_pin_c_in;
    adc_n <= adc_n + 32'(adc_start_out);
    clr_n <= clr_n + 32'(counter_cleared_out);
    c_edges <= c_edges + 32'(ext_clock_pin_c_in && !pc_d);
  end
  initial begin
    #2000000;
    err_total++;
    summarize();
  end
  initial begin
    void'($urandom(50348));
    repeat (5) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    rd(tcs_pkg::ADR_GRA, 16'hffff, tcs_pkg::GR_RST);
    rd(tcs_pkg::ADR_GRB, 16'hffff, tcs_pkg::GR_RST);
    rd(tcs_pkg::ADR_CTRL, 16'hffff, 16'h0000);
    rd(tcs_pkg::ADR_STATUS, 16'hffff, 16'h00c0);
    rd(tcs_pkg::ADR_TRIG, 16'hffff, 16'h0040);
    rd(16'hffe0, 16'hffff, 16'h0000);
    for (int m = 0; m < 8; m++) begin
      wr(tcs_pkg::ADR_MODE, 16'(m));
      rd(tcs_pkg::ADR_MODE, 16'hffff, 16'(m) | 16'h00c0);
    end
    $display("end reset and mode codes");
    // mode 7 counts by phase on idle pins: no tick overtakes the count write
    g = $urandom_range(40, 8);
    wr(tcs_pkg::ADR_COUNT, 16'h0000);
    wr(tcs_pkg::ADR_GRA, 16'(g));
    wr(tcs_pkg::ADR_TRIG, 16'h0080);
    wr(tcs_pkg::ADR_MODE, 16'h0000);
    await(0);
    repeat (2) @(posedge clock_in);
    chk("flag_a", 16'h1, 16'(fl[0]));
    chk("adc_starts", 16'h1, 16'(adc_n));
    wr(tcs_pkg::ADR_STATUS, 16'h00ff);
    chk("flag_a", 16'h1, 16'(fl[0]));
    wr(tcs_pkg::ADR_STATUS, 16'h0000);
    chk("flag_a", 16'h1, 16'(fl[0]));
    rd(tcs_pkg::ADR_STATUS, 16'h0001, 16'h0001);
    wr(tcs_pkg::ADR_STATUS, 16'h0000);
    chk("flag_a", 16'h0, 16'(fl[0]));
    wr(tcs_pkg::ADR_MODE, 16'h0004);
    wr(tcs_pkg::ADR_COUNT, 16'hfffc);
    wr(tcs_pkg::ADR_MODE, 16'h0000);
    await(2);
    chk("ovf", 16'h1, 16'(fl[2]));
    rd(tcs_pkg::ADR_STATUS, 16'h0010, 16'h0010);
    wr(tcs_pkg::ADR_STATUS, 16'h0000);
    chk("ovf", 16'h0, 16'(fl[2]));
    $display("end compare and overflow");
    wr(tcs_pkg::ADR_IOSEL, 16'h0003);
    rd(tcs_pkg::ADR_STATUS, 16'h0002, 16'h0000);
    wr(tcs_pkg::ADR_STATUS, 16'h0000);
    pulse(5'h03);
    chk("flags_ab", 16'h3, 16'(fl[1:0]));
    transfer_irq_select_a_in <= 1'b1;
    pulse(5'h08);
    chk("flag_a", 16'h1, 16'(fl[0]));
    transfer_irq_select_a_in <= 1'b0;
    pulse(5'h18);
    chk("flags_ab", 16'h0, 16'(fl[1:0]));
    for (int c = 0; c < 4; c++) begin
      wr(tcs_pkg::ADR_CTRL, 16'(c << 5));
      b = clr_n;
      pulse(5'h06);
      repeat (3) @(posedge clock_in);
      chk("clears", 16'(b + 32'(c > 1)), 16'(clr_n));
    end
    $display("end capture and clear");
    wr(tcs_pkg::ADR_CTRL, 16'h0006);
    wr(tcs_pkg::ADR_COUNT, 16'h0000);
    b = c_edges;
    tog_c <= 1'b1;
    repeat (40) @(posedge clock_in);
    tog_c <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd(tcs_pkg::ADR_COUNT, 16'hffff, 16'(c_edges - b));
    wr(tcs_pkg::ADR_CTRL, 16'h001f);
    wr(tcs_pkg::ADR_MODE, 16'h0004);
    wr(tcs_pkg::ADR_COUNT, 16'h0002);
    q_dn <= 1'b1;
    q_on <= 1'b1;
    await(3);
    q_on <= 1'b0;
    chk("udf", 16'h1, 16'(fl[3]));
    repeat (8) @(posedge clock_in);
    rd(tcs_pkg::ADR_STATUS, 16'h00a0, 16'h0020);
    wr(tcs_pkg::ADR_STATUS, 16'h0000);
    chk("udf", 16'h0, 16'(fl[3]));
    q_dn <= 1'b0;
    q_on <= 1'b1;
    repeat (16) @(posedge clock_in);
    q_on <= 1'b0;
    repeat (8) @(posedge clock_in);
    rd(tcs_pkg::ADR_STATUS, 16'h0080, 16'h0080);
    // a capture while the enable is low must be lost
    ce_in <= 1'b0;
    pulse(5'h01);
    ce_in <= 1'b1;
    chk("flag_a", 16'h0, 16'(fl[0]));
    repeat (2) @(posedge clock_in);
    $display("end pins, phase counting and enable");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
